// >>> measurement_control_io_port.sv
// Operation
// [RULE1] external source: one measurement per selected trigger edge
// [RULE2] trigger edge selectable falling or rising, falling after reset
// [RULE3] internal source: trigger input starts no measurement
// [RULE4] enabled settings monitor with error blocks all triggering
// [RULE5] accepted edge requests statistics and memory stores when enabled
// [RULE6] zero-adjust falling edge launches one zero adjustment
// [RULE7] handler holds zero-adjust low at least 10 ms
// [RULE8] print falling edge prints current value once
// [RULE9] calibration falling edge runs self calibration only in manual view
// [RULE10] self calibration lasts 130 ms at 60 Hz, 110 ms at 50 Hz
// [RULE11] calibration requested during measurement waits for its end
// [RULE12] force-external low selects external source, high restores setting
// [RULE13] probe-test falling edge runs one short detection
// [RULE14] probe test during measurement runs a set delay after its end
// [RULE15] panel-lock low disables all keys except power
// [RULE16] fault output for non-range errors, updated with end, kills judgments
// [RULE17] two contact-error outputs, updated with end, kill judgments
// [RULE18] probe-bridged output asserted on detection, judgments held off
// [RULE19] conversion-done asserted when conversion completes
// [RULE20] end-of-measurement asserted only after all results settled
// [RULE21] inputs ignored on setting, stats or error views; print on stats
// [RULE22] no input action or output update while settings change
// [RULE23] all outputs active low
// [RULE24] hold mode keeps end asserted until next trigger starts measuring
// [RULE25] trigger during running external measurement is dropped
// [RULE26] inputs synchronised before edge detection, one pulse per edge
// [RULE27] judgment outputs mutually exclusive
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module measurement_control_io_port
    import ctrl_io_pkg::*;
#(
    parameter int unsigned CAL_60_CYCLES = CAL_60HZ_CYC,
    parameter int unsigned CAL_50_CYCLES = CAL_50HZ_CYC
) (
    input  wire logic        clock,                 // system clock
    input  wire logic        rst_n,                 // sync reset
    // avalon-mm slave
    input  wire logic [4:0]  address,               // byte address
    input  wire logic        read,                  // read request
    input  wire logic        write,                 // write request
    input  wire logic [31:0] writedata,             // write data
    output logic [31:0]      readdata,              // read data
    output logic             waitrequest,           // stall
    // control pins, active low
    input  wire logic        measure_trigger_in_n,  // trigger
    input  wire logic        zero_adjust_in_n,      // zero adjust
    input  wire logic        print_in_n,            // print request
    input  wire logic        self_cal_in_n,         // self calibration
    input  wire logic        force_ext_in_n,        // force external src
    input  wire logic        probe_short_test_in_n, // probe short test
    input  wire logic        panel_lock_in_n,       // panel lock
    // result pins, active low
    output logic             measurement_done_out_n,    // end of meas
    output logic             conversion_done_n,         // a/d finished
    output logic             judge_above_n,             // above limits
    output logic             judge_within_n,            // within limits
    output logic             judge_below_n,             // below limits
    output logic             meas_fault_n,              // meas error
    output logic             high_side_contact_fault_n, // high contact
    output logic             low_side_contact_fault_n,  // low contact
    output logic             probe_bridged_fault_n,     // probe short
    // measurement engine handshake
    input  wire logic        engine_busy,           // measuring
    input  wire logic        adc_done,              // conversion pulse
    input  wire logic        meas_end,              // result pulse
    input  wire logic        res_above,             // result above
    input  wire logic        res_within,            // result within
    input  wire logic        res_below,             // result below
    input  wire logic        res_error,             // non-range error
    input  wire logic        res_contact_hi,        // high contact err
    input  wire logic        res_contact_lo,        // low contact err
    input  wire logic        probe_done,            // short test done
    input  wire logic        probe_found,           // short found
    output logic             meas_start,            // start pulse
    output logic             stat_store,            // stats store pulse
    output logic             mem_store,             // memory store pulse
    output logic             zero_adjust_start,     // zero adj pulse
    output logic             print_start,           // print pulse
    output logic             cal_start,             // calibration pulse
    output logic             cal_busy,              // calibrating
    output logic             probe_test_start,      // short test pulse
    output logic             keys_locked            // panel keys locked
);

    logic [NUM_IN-1:0] lvl, fall, rise;
    logic [CTRL_BITS-1:0] ctrl_q;
    logic [VIEW_BITS-1:0] view_q;
    logic [31:0] prb_delay_q, eom_width_q, eom_cnt_q, cal_cnt_q, prb_cnt_q;
    logic        ext_busy_q, eom_on_q, eom_pend_q;
    cal_state_t  cal_state_q;
    prb_state_t  prb_state_q;
    logic inputs_ok, print_ok, changing, ext_src, meas_active;
    logic measure_trigger_in_edge, measure_trigger_in_ok, start_meas, any_fault;

    if (CAL_60_CYCLES < 1 || CAL_50_CYCLES < 1) begin : g_chk
        $error("calibration cycle counts must be at least one");
    end

    // inputs are synchronised before any edge is taken
    input_conditioner #(.W(NUM_IN)) u_cond ( // RULE26
        .clock   (clock),
        .rst_n   (rst_n),
        .pins_n  ({panel_lock_in_n, probe_short_test_in_n, force_ext_in_n,
                   self_cal_in_n, print_in_n, zero_adjust_in_n,
                   measure_trigger_in_n}),
        .level_q (lvl),
        .fall_q  (fall),
        .rise_q  (rise)
    );

    // input gating by displayed view and settings change
    assign changing  = view_q[VIEW_CHANGING];
    assign print_ok  = !(view_q[VIEW_SETTINGS] || view_q[VIEW_COMPARE] ||
                         view_q[VIEW_ERRMSG] || changing); // RULE21 RULE22
    assign inputs_ok = print_ok && !view_q[VIEW_STATS]; // RULE21
    assign ext_src   = lvl[IN_FORCE] || !ctrl_q[CTRL_INT_SRC]; // RULE12
    assign meas_active = ext_busy_q || engine_busy;
    assign measure_trigger_in_edge = ctrl_q[CTRL_RISE_EDGE] ? rise[IN_MEASURE_TRIGGER_IN]
                                              : fall[IN_MEASURE_TRIGGER_IN]; // RULE2
    assign measure_trigger_in_ok   = inputs_ok && measure_trigger_in_edge &&
                       !(ctrl_q[CTRL_MON_EN] && ctrl_q[CTRL_MON_ERR]); // RULE4
    // busy or calibrating drops the edge rather than queueing it
    assign start_meas = measure_trigger_in_ok && ext_src && !meas_active &&
                        cal_state_q != CAL_RUN; // RULE1 RULE3 RULE25
    assign any_fault = res_error || res_contact_hi || res_contact_lo ||
                       !probe_bridged_fault_n;

    // bus slave: one wait cycle, then answer; waitrequest idles high
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                case (address)
                    ADDR_CTRL:      readdata <= {24'h00_0000, ctrl_q};
                    ADDR_VIEW:      readdata <= {26'h000_0000, view_q};
                    ADDR_PRB_DELAY: readdata <= prb_delay_q;
                    ADDR_EOM_WIDTH: readdata <= eom_width_q;
                    ADDR_STATUS:    readdata <= {24'h00_0000,
                        cal_busy, prb_state_q != PRB_IDLE, ext_busy_q,
                        ext_src, lvl[IN_FORCE], lvl[IN_LOCK],
                        !probe_bridged_fault_n, eom_on_q};
                    default:        readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // register writes take effect on the answering edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q      <= CTRL_RESET; // RULE2
            view_q      <= VIEW_RESET;
            prb_delay_q <= PRB_DELAY_RESET;
            eom_width_q <= EOM_WIDTH_RESET;
        end else if (write && !waitrequest) begin
            case (address)
                ADDR_CTRL:      ctrl_q      <= writedata[CTRL_BITS-1:0];
                ADDR_VIEW:      view_q      <= writedata[VIEW_BITS-1:0];
                ADDR_PRB_DELAY: prb_delay_q <= writedata;
                ADDR_EOM_WIDTH: eom_width_q <= writedata;
                default:        ;
            endcase
        end
    end

    // trigger side requests to the engine
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meas_start <= 1'b0;
            stat_store <= 1'b0;
            mem_store  <= 1'b0;
            ext_busy_q <= 1'b0;
        end else begin
            meas_start <= start_meas; // RULE1
            stat_store <= start_meas && ctrl_q[CTRL_STAT_EN]; // RULE5
            mem_store  <= ctrl_q[CTRL_MEM_EN] &&
                          (start_meas || (measure_trigger_in_ok && !ext_src)); // RULE5
            if (start_meas)
                ext_busy_q <= 1'b1;
            else if (meas_end)
                ext_busy_q <= 1'b0;
        end
    end

    // single-shot commands and the panel lock level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            zero_adjust_start <= 1'b0;
            print_start       <= 1'b0;
            keys_locked       <= 1'b0;
        end else begin
            zero_adjust_start <= fall[IN_ZERO] && inputs_ok; // RULE6
            print_start       <= fall[IN_PRINT] && print_ok; // RULE8
            if (inputs_ok)
                keys_locked <= lvl[IN_LOCK]; // RULE15
        end
    end

    // self calibration; a request mid-measurement waits for its end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cal_state_q <= CAL_IDLE;
            cal_cnt_q   <= 32'h0000_0000;
            cal_start   <= 1'b0;
            cal_busy    <= 1'b0;
        end else begin
            cal_start <= 1'b0;
            case (cal_state_q)
                CAL_IDLE:
                    if (fall[IN_CAL] && inputs_ok &&
                        view_q[VIEW_MANCAL]) begin // RULE9
                        cal_state_q <= CAL_DEFER; // RULE11
                    end
                CAL_DEFER:
                    if (!meas_active) begin // RULE11
                        cal_state_q <= CAL_RUN;
                        cal_start   <= 1'b1;
                        cal_busy    <= 1'b1;
                        cal_cnt_q   <= ctrl_q[CTRL_LINE_50]
                                       ? CAL_50_CYCLES[31:0]
                                       : CAL_60_CYCLES[31:0]; // RULE10
                    end
                CAL_RUN:
                    if (cal_cnt_q <= 32'h0000_0001) begin // RULE10
                        cal_state_q <= CAL_IDLE;
                        cal_busy    <= 1'b0;
                    end else begin
                        cal_cnt_q <= cal_cnt_q - 32'h0000_0001;
                    end
                default: cal_state_q <= CAL_IDLE;
            endcase
        end
    end

    // probe short test; mid-measurement request runs a delay after end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prb_state_q      <= PRB_IDLE;
            prb_cnt_q        <= 32'h0000_0000;
            probe_test_start <= 1'b0;
        end else begin
            probe_test_start <= 1'b0;
            case (prb_state_q)
                PRB_IDLE:
                    if (fall[IN_PROBE] && inputs_ok) begin // RULE13
                        if (meas_active)
                            prb_state_q <= PRB_DEFER; // RULE14
                        else
                            probe_test_start <= 1'b1; // RULE13
                    end
                PRB_DEFER:
                    if (!meas_active) begin
                        prb_state_q <= PRB_HOLDOFF;
                        prb_cnt_q   <= prb_delay_q; // RULE14
                    end
                PRB_HOLDOFF:
                    if (prb_cnt_q == 32'h0000_0000) begin // RULE14
                        prb_state_q      <= PRB_IDLE;
                        probe_test_start <= 1'b1;
                    end else begin
                        prb_cnt_q <= prb_cnt_q - 32'h0000_0001;
                    end
                default: prb_state_q <= PRB_IDLE;
            endcase
        end
    end

    // judgment and fault pins, all held as active-low flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            judge_above_n             <= 1'b1; // RULE23
            judge_within_n            <= 1'b1;
            judge_below_n             <= 1'b1;
            meas_fault_n              <= 1'b1;
            high_side_contact_fault_n <= 1'b1;
            low_side_contact_fault_n  <= 1'b1;
            probe_bridged_fault_n     <= 1'b1;
        end else if (!changing) begin // RULE22
            if (meas_end) begin
                meas_fault_n              <= !res_error; // RULE16
                high_side_contact_fault_n <= !res_contact_hi; // RULE17
                low_side_contact_fault_n  <= !res_contact_lo; // RULE17
                // priority order keeps the three mutually exclusive
                judge_above_n  <= any_fault || !res_above; // RULE27
                judge_below_n  <= any_fault || res_above ||
                                  !res_below; // RULE27
                judge_within_n <= any_fault || res_above || res_below ||
                                  !res_within; // RULE16 RULE17 RULE27
            end else if (start_meas) begin
                // internal source leaves last results standing
                judge_above_n             <= 1'b1;
                judge_within_n            <= 1'b1;
                judge_below_n             <= 1'b1;
                meas_fault_n              <= 1'b1;
                high_side_contact_fault_n <= 1'b1;
                low_side_contact_fault_n  <= 1'b1;
            end
            if (probe_done) begin
                probe_bridged_fault_n <= !probe_found; // RULE18
                if (probe_found) begin
                    judge_above_n  <= 1'b1; // RULE18
                    judge_within_n <= 1'b1;
                    judge_below_n  <= 1'b1;
                end
            end
        end
    end

    // end and conversion pins; end follows results by one cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            eom_pend_q             <= 1'b0;
            eom_on_q               <= 1'b0;
            eom_cnt_q              <= 32'h0000_0000;
            measurement_done_out_n <= 1'b1;
            conversion_done_n      <= 1'b1;
        end else if (!changing) begin // RULE22
            eom_pend_q <= meas_end;
            if (eom_pend_q) begin
                eom_on_q  <= 1'b1;
                eom_cnt_q <= eom_width_q;
                // end pin stays released under the internal source
                measurement_done_out_n <= !ext_src; // RULE20
            end else if (start_meas) begin
                eom_on_q               <= 1'b0; // RULE24
                measurement_done_out_n <= 1'b1;
                conversion_done_n      <= 1'b1;
            end else if (eom_on_q && !ctrl_q[CTRL_HOLD_MODE]) begin
                if (eom_cnt_q <= 32'h0000_0001) begin
                    eom_on_q               <= 1'b0;
                    measurement_done_out_n <= 1'b1;
                    conversion_done_n      <= 1'b1;
                end else begin
                    eom_cnt_q <= eom_cnt_q - 32'h0000_0001;
                end
            end
            // placed last so a conversion beats a release in the same cycle
            if (adc_done)
                conversion_done_n <= 1'b0; // RULE19
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence end_settles_s;
        meas_end && ext_src && !changing ##1 !changing;
    endsequence

    start_on_edge_a: assert property ( // RULE1
        start_meas |=> meas_start ##1 !meas_start)
        else $error("trigger edge did not give one start pulse");
    int_source_a: assert property ( // RULE3
        !ext_src |=> !meas_start)
        else $error("start pulse under internal source");
    monitor_block_a: assert property ( // RULE4
        ctrl_q[CTRL_MON_EN] && ctrl_q[CTRL_MON_ERR] |=>
        !meas_start && !mem_store && !stat_store)
        else $error("trigger passed a settings monitor error");
    busy_drop_a: assert property ( // RULE25
        ext_busy_q |=> !meas_start)
        else $error("trigger accepted while measuring");
    judge_excl_a: assert property ( // RULE27
        $onehot0({!judge_above_n, !judge_within_n, !judge_below_n}))
        else $error("more than one judgment asserted");
    fault_kills_a: assert property ( // RULE16 RULE17 RULE18
        !(meas_fault_n && high_side_contact_fault_n &&
          low_side_contact_fault_n && probe_bridged_fault_n) |->
        judge_above_n && judge_within_n && judge_below_n)
        else $error("judgment asserted alongside a fault");
    end_after_result_a: assert property ( // RULE20
        end_settles_s |=> !measurement_done_out_n &&
        $stable({judge_above_n, judge_within_n, judge_below_n,
                 meas_fault_n}))
        else $error("end asserted before results settled");
    hold_mode_a: assert property ( // RULE24
        ctrl_q[CTRL_HOLD_MODE] && !measurement_done_out_n && !eom_pend_q
        && !start_meas |=> !measurement_done_out_n)
        else $error("end released in hold mode without a trigger");
    cal_defer_a: assert property ( // RULE11
        cal_state_q == CAL_DEFER && meas_active |=> !cal_start)
        else $error("calibration started during a measurement");
    view_ignore_a: assert property ( // RULE21
        view_q[VIEW_SETTINGS] |=> !zero_adjust_start && !meas_start &&
        !print_start && !probe_test_start)
        else $error("input acted on while a settings view is shown");

endmodule // measurement_control_io_port

// >>> ctrl_io_pkg.sv
package ctrl_io_pkg;

    // clock rate and derived cycle counts
    localparam int unsigned CLK_FREQ_HZ  = 250_000_000;
    localparam int unsigned CYC_PER_MS   = CLK_FREQ_HZ / 1000;
    localparam int unsigned CAL_60HZ_MS  = 130;
    localparam int unsigned CAL_50HZ_MS  = 110;
    localparam int unsigned CAL_60HZ_CYC = CAL_60HZ_MS * CYC_PER_MS;
    localparam int unsigned CAL_50HZ_CYC = CAL_50HZ_MS * CYC_PER_MS;

    // register byte offsets
    localparam logic [4:0] ADDR_CTRL      = 5'h00;
    localparam logic [4:0] ADDR_VIEW      = 5'h04;
    localparam logic [4:0] ADDR_PRB_DELAY = 5'h08;
    localparam logic [4:0] ADDR_EOM_WIDTH = 5'h0c;
    localparam logic [4:0] ADDR_STATUS    = 5'h10;

    // control register fields
    localparam int CTRL_INT_SRC   = 0;
    localparam int CTRL_RISE_EDGE = 1;
    localparam int CTRL_HOLD_MODE = 2;
    localparam int CTRL_STAT_EN   = 3;
    localparam int CTRL_MEM_EN    = 4;
    localparam int CTRL_MON_EN    = 5;
    localparam int CTRL_LINE_50   = 6;
    localparam int CTRL_MON_ERR   = 7;
    localparam int CTRL_BITS      = 8;

    // view register fields
    localparam int VIEW_SETTINGS = 0;
    localparam int VIEW_COMPARE  = 1;
    localparam int VIEW_STATS    = 2;
    localparam int VIEW_ERRMSG   = 3;
    localparam int VIEW_MANCAL   = 4;
    localparam int VIEW_CHANGING = 5;
    localparam int VIEW_BITS     = 6;

    // reset values
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [5:0]  VIEW_RESET      = 6'h00;
    localparam logic [31:0] PRB_DELAY_RESET = 32'h0000_03e8;
    localparam logic [31:0] EOM_WIDTH_RESET = 32'h0003_d090;

    // control input indices
    localparam int IN_MEASURE_TRIGGER_IN  = 0;
    localparam int IN_ZERO  = 1;
    localparam int IN_PRINT = 2;
    localparam int IN_CAL   = 3;
    localparam int IN_FORCE = 4;
    localparam int IN_PROBE = 5;
    localparam int IN_LOCK  = 6;
    localparam int NUM_IN   = 7;

    typedef enum logic [1:0] {CAL_IDLE, CAL_DEFER, CAL_RUN} cal_state_t;
    typedef enum logic [1:0] {PRB_IDLE, PRB_DEFER, PRB_HOLDOFF} prb_state_t;

endpackage

// >>> input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner #(
    parameter int W = 7
) (
    input  wire logic         clock,    // system clock
    input  wire logic         rst_n,    // synchronous reset
    input  wire logic [W-1:0] pins_n,   // raw active-low pins
    output logic      [W-1:0] level_q,  // asserted level, synced
    output logic      [W-1:0] fall_q,   // one pulse per high-to-low
    output logic      [W-1:0] rise_q    // one pulse per low-to-high
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    if (W < 1) begin : g_chk
        $error("input_conditioner needs at least one input");
    end

    // two-stage synchroniser; meta_q feeds sync_q and nothing else
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= pins_n;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges taken after sync so a bouncing pin gives one pulse per change
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level_q <= '0;
            fall_q  <= '0;
            rise_q  <= '0;
        end else begin
            level_q <= ~sync_q;
            fall_q  <= prev_q & ~sync_q;
            rise_q  <= ~prev_q & sync_q;
        end
    end

endmodule // input_conditioner

// >>> engine_model.sv
`timescale 1ns/1ps
module engine_model (
    input  wire logic       clock,            // system clock
    input  wire logic       meas_start,       // start pulse
    input  wire logic       probe_test_start, // short test pulse
    input  wire logic [5:0] result,           // above,within,below,err,chi,clo
    output logic            engine_busy = 0,  // measuring
    output logic            adc_done = 0,     // conversion pulse
    output logic            meas_end = 0,     // result pulse
    output logic      [5:0] res = 6'h00,      // result levels
    output logic            probe_done = 0    // short test done
);
    logic [3:0] cnt_q = 4'h0;
    // fixed 8-cycle measurement; levels churn outside meas_end on purpose
    always @(posedge clock) begin
        cnt_q       <= meas_start ? 4'h8 : cnt_q - (cnt_q != 4'h0);
        engine_busy <= meas_start || cnt_q > 4'h1;
        adc_done    <= cnt_q == 4'h4;
        meas_end    <= cnt_q == 4'h1;
        res         <= (cnt_q == 4'h1) ? result : ~res;
        probe_done  <= probe_test_start;
    end
endmodule // engine_model

// >>> tb_measurement_control_io_port.sv
`timescale 1ns/1ps
module tb_measurement_control_io_port;
    import ctrl_io_pkg::*;
    logic clock = 0, rst_n = 0, read = 0, write = 0, engine_busy, adc_done;
    logic [4:0]  address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [6:0]  pins_n = 7'h7f;
    logic [5:0]  result = 6'h10, res;
    logic waitrequest, measurement_done_out_n, conversion_done_n, judge_above_n,
        judge_within_n, judge_below_n, meas_fault_n, high_side_contact_fault_n,
        low_side_contact_fault_n, probe_bridged_fault_n, meas_end, probe_done,
        meas_start, stat_store, mem_store, zero_adjust_start, print_start,
        cal_start, cal_busy, probe_test_start, keys_locked, pf = 0;
    int n_mismatch = 0, checks = 0, n_ms = 0, n_mem = 0, n_pr = 0, n_za = 0;
    measurement_control_io_port #(.CAL_60_CYCLES(20), .CAL_50_CYCLES(15))
    i_dut (.*, .measure_trigger_in_n(pins_n[IN_MEASURE_TRIGGER_IN]),
        .zero_adjust_in_n(pins_n[IN_ZERO]), .print_in_n(pins_n[IN_PRINT]),
        .self_cal_in_n(pins_n[IN_CAL]), .force_ext_in_n(pins_n[IN_FORCE]),
        .probe_short_test_in_n(pins_n[IN_PROBE]),
        .panel_lock_in_n(pins_n[IN_LOCK]), .res_above(res[5]),
        .res_within(res[4]), .res_below(res[3]), .res_error(res[2]),
        .res_contact_hi(res[1]), .res_contact_lo(res[0]), .probe_found(pf));
    engine_model i_eng (.clock(clock), .meas_start(meas_start),
        .probe_test_start(probe_test_start), .result(result),
        .engine_busy(engine_busy), .adc_done(adc_done), .meas_end(meas_end),
        .res(res), .probe_done(probe_done));
    always #2 clock = ~clock;
    // pulse tallies; trigger checks compare differences, zero-adjust and print checks compare totals; never cleared
    always @(posedge clock) begin
        n_ms  <= n_ms + meas_start;
        n_mem <= n_mem + mem_store + stat_store;
        n_pr  <= n_pr + print_start;
        n_za  <= n_za + zero_adjust_start;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    // avalon master: hold request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        read <= !wr; write <= wr; address <= a; writedata <= d;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0; write <= 0;
        @(posedge clock);
    endtask
    // pins held 16 cycles, well over the 3-cycle sync need
    task automatic pin(input int i, input logic lv);
        pins_n[i] <= lv;
        repeat (16) @(posedge clock);
    endtask
    task automatic measure_trigger_in(input logic rise, input int e_ms, input int e_mem);
        int a = n_ms, b = n_mem;
        pin(IN_MEASURE_TRIGGER_IN, 0);
        chk(n_ms - a, rise ? 0 : e_ms);
        pin(IN_MEASURE_TRIGGER_IN, 1);
        chk(n_ms - a, e_ms);
        chk(n_mem - b, e_mem);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1;
        bus(0, ADDR_PRB_DELAY, 0); chk(q, PRB_DELAY_RESET);
        bus(0, 5'h14, 0); chk(q, 0);
        bus(1, ADDR_EOM_WIDTH, 32'h40);
        measure_trigger_in(0, 1, 0);
        chk_bit(judge_within_n, 0); chk_bit(measurement_done_out_n, 0);
        chk_bit(conversion_done_n, 0);
        pf <= 1; pin(IN_PROBE, 0); pin(IN_PROBE, 1);
        chk_bit(probe_bridged_fault_n, 0); chk_bit(judge_within_n, 1);
        repeat (80) @(posedge clock);
        result <= 6'h17;
        measure_trigger_in(0, 1, 0);
        chk_bit(meas_fault_n, 0); chk_bit(judge_within_n, 1);
        chk_bit(high_side_contact_fault_n, 0);
        chk_bit(low_side_contact_fault_n, 0);
        repeat (80) @(posedge clock);
        bus(1, ADDR_CTRL, 32'h1 << CTRL_RISE_EDGE | 32'h1 << CTRL_STAT_EN
            | 32'h1 << CTRL_HOLD_MODE);
        measure_trigger_in(1, 1, 1);
        repeat (80) @(posedge clock);
        chk_bit(measurement_done_out_n, 0);
        bus(1, ADDR_CTRL, 32'h1 << CTRL_INT_SRC | 32'h1 << CTRL_MEM_EN);
        measure_trigger_in(0, 0, 1);
        // zero-adjust and lock stay low for the rest of the run
        pin(IN_ZERO, 0); chk(n_za, 1);
        pin(IN_LOCK, 0); chk_bit(keys_locked, 1);
        bus(1, ADDR_VIEW, 32'h1 << VIEW_MANCAL);
        pin(IN_CAL, 0); chk_bit(cal_busy, 1);
        pin(IN_CAL, 1); chk_bit(cal_busy, 0);
        bus(1, ADDR_VIEW, 32'h1 << VIEW_SETTINGS);
        pin(IN_PRINT, 0); pin(IN_PRINT, 1); chk(n_pr, 0);
        bus(1, ADDR_VIEW, 32'h1 << VIEW_STATS);
        pin(IN_PRINT, 0); pin(IN_PRINT, 1); chk(n_pr, 1);
        summarize();
    end
endmodule // tb_measurement_control_io_port
